/* dpc_loop_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - eight-bit feedback count at feedback_divide_count, 6..127
// RULE2 - sample clock = 2 x count x fref/ratio
// RULE3 - host keeps phase detector 35..80 MHz
// RULE4 - vco divider select decodes 4/8/16
// RULE5 - host keeps vco within 6..12 GHz
// RULE6 - six-bit charge pump current code at charge_pump_code
// RULE7 - charge pump calibration enabled from reset
// RULE8 - calibrate once, keep coefficient afterwards
// RULE9 - charge pump calibration lasts 64 cycles
// RULE10 - status bit 5 shows calibration done
// RULE11 - writing 0x10 to loop_enable_control enables loop
// RULE12 - automatic selection of one of 512 bands
// RULE13 - status bit 1 reports loop lock
// RULE14 - host writes tracking registers per vco frequency
// RULE15 - host follows documented start order
// RULE16 - status bits 7/6 show band edges
// RULE17 - recal bit cleared then set recalibrates
// RULE18 - lock/lost events enabled, read, cleared
// RULE19 - five four-bit loop filter codes
// RULE20 - reference select decodes 1,2,4,8,16
// RULE21 - clocks powered down after reset
// RULE22 - status bits read-only live, writes ignored
module dpc_loop_ctrl
  import dpc_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       nrst,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [8:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  output logic      [7:0]                 reg_rdata,
  input  wire logic                       lock_detect_raw,
  input  wire logic                       band_upper_raw,
  input  wire logic                       band_lower_raw,
  input  wire logic                       vco_fast_raw,
  output logic                            loop_enable,
  output logic                            cp_cal_run,
  output logic                            cp_cal_valid,
  output logic                            band_search_run,
  output logic      [dpc_pkg::BAND_W-1:0] vco_band,
  output logic      [7:0]                 feedback_divide_count,
  output logic      [8:0]                 sample_clock_multiplier,
  output logic      [4:0]                 reference_divide_ratio,
  output logic      [4:0]                 vco_output_divide_ratio,
  output logic      [dpc_pkg::CP_W-1:0]   charge_pump_code,
  output logic      [7:0]                 loop_filter_a,
  output logic      [7:0]                 loop_filter_b,
  output logic      [7:0]                 loop_filter_c,
  output logic      [7:0]                 vco_tracking_a,
  output logic      [7:0]                 vco_tracking_b,
  output logic      [7:0]                 vco_tracking_c,
  output logic      [4:0]                 clock_power_up
);
  import dpc_pkg::*;

  dpc_regs_t q;
  dpc_regs_t d;
  logic       en;
  logic       recal;
  logic       lock_now;
  logic [7:0] status;
  logic [3:0] nb;

  always_comb begin
    d        = q;
    en       = q.ctrl[CTRL_EN_BIT];
    recal    = 1'b0;
    lock_now = q.s2[0] & (q.st == ST_TRACK);
    nb       = q.bit_idx - 4'h1;
    // live status
    status   = {q.s2[1], q.s2[2], q.cal_done, 3'h0,
                lock_now, 1'b0}; // RULE10 RULE13 RULE16 RULE22

    // pin synchronisers
    d.s1 = {vco_fast_raw, band_lower_raw, band_upper_raw, lock_detect_raw};
    d.s2 = q.s1;
    d.lock_prev = lock_now;

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_IRQ_EN:  d.irq_en  = reg_wdata;
        ADDR_IRQ_ST:  d.irq_st  = q.irq_st & ~reg_wdata; // RULE18
        ADDR_CLK_PWR: d.clk_pwr = reg_wdata; // RULE21
        ADDR_CTRL: begin
          d.ctrl = reg_wdata; // RULE11
          recal  = reg_wdata[CTRL_RECAL_BIT]
                   & ~q.ctrl[CTRL_RECAL_BIT]; // RULE17
        end
        ADDR_FB_CNT:  d.fb_cnt  = reg_wdata; // RULE1
        ADDR_LF_A:    d.lf_a    = reg_wdata; // RULE19
        ADDR_LF_B:    d.lf_b    = reg_wdata; // RULE19
        ADDR_LF_C:    d.lf_c    = reg_wdata; // RULE19
        ADDR_CP:      d.cp      = reg_wdata[CP_W-1:0]; // RULE6
        ADDR_VDIV:    d.vdiv    = reg_wdata[1:0];
        ADDR_RDIV:    d.rdiv    = reg_wdata[2:0];
        ADDR_TRK_A:   d.trk_a   = reg_wdata;
        ADDR_TRK_B:   d.trk_b   = reg_wdata;
        ADDR_TRK_C:   d.trk_c   = reg_wdata;
        default: ;
      endcase
    end

    // event capture, set wins over clear
    if (q.irq_en[IRQ_LOCK_BIT] & lock_now & ~q.lock_prev) begin
      d.irq_st[IRQ_LOCK_BIT] = 1'b1; // RULE18
    end
    if (q.irq_en[IRQ_LOST_BIT] & ~lock_now & q.lock_prev) begin
      d.irq_st[IRQ_LOST_BIT] = 1'b1; // RULE18
    end

    // loop sequencer
    unique case (q.st)
      ST_IDLE: begin
        d.cnt = 7'h00;
        if (en) begin
          if (q.cal_done) begin
            d.st      = ST_BAND; // RULE8
            d.band    = BAND_MID;
            d.bit_idx = BAND_TOP;
          end else begin
            d.st = ST_CPCAL; // RULE7
          end
        end
      end
      ST_CPCAL: begin
        if (!en) begin
          d.st = ST_IDLE;
        end else if (q.cnt == CP_CAL_LAST) begin
          d.cal_done = 1'b1; // RULE9 RULE10
          d.st       = ST_BAND;
          d.cnt      = 7'h00;
          d.band     = BAND_MID;
          d.bit_idx  = BAND_TOP;
        end else begin
          d.cnt = q.cnt + 7'h01; // RULE9
        end
      end
      ST_BAND: begin
        if (!en) begin
          d.st = ST_IDLE;
        end else if (recal) begin
          d.cnt     = 7'h00;
          d.band    = BAND_MID;
          d.bit_idx = BAND_TOP;
        end else if (q.cnt == SETTLE_LAST) begin
          d.cnt = 7'h00;
          // successive approximation over the bands
          if (q.s2[3]) begin
            d.band[q.bit_idx] = 1'b0; // RULE12
          end
          if (q.bit_idx == 4'h0) begin
            d.st = ST_TRACK;
          end else begin
            d.bit_idx  = nb;
            d.band[nb] = 1'b1; // RULE12
          end
        end else begin
          d.cnt = q.cnt + 7'h01;
        end
      end
      ST_TRACK: begin
        if (!en) begin
          d.st = ST_IDLE;
        end else if (recal) begin
          d.st      = ST_BAND; // RULE17
          d.cnt     = 7'h00;
          d.band    = BAND_MID;
          d.bit_idx = BAND_TOP;
        end
      end
    endcase

    // registered ratio decode
    d.ref_ratio = dpc_ref_ratio(q.rdiv); // RULE20
    d.vco_ratio = dpc_vco_ratio(q.vdiv); // RULE4
    d.mult      = {q.fb_cnt, 1'b0}; // RULE2

    // register reads
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_IRQ_EN:  d.rdata = q.irq_en;
        ADDR_IRQ_ST:  d.rdata = q.irq_st;
        ADDR_CLK_PWR: d.rdata = q.clk_pwr;
        ADDR_CTRL:    d.rdata = q.ctrl;
        ADDR_STATUS:  d.rdata = status;
        ADDR_FB_CNT:  d.rdata = q.fb_cnt;
        ADDR_LF_A:    d.rdata = q.lf_a;
        ADDR_LF_B:    d.rdata = q.lf_b;
        ADDR_LF_C:    d.rdata = q.lf_c;
        ADDR_CP:      d.rdata = {2'h0, q.cp};
        ADDR_VDIV:    d.rdata = {6'h00, q.vdiv};
        ADDR_RDIV:    d.rdata = {5'h00, q.rdiv};
        ADDR_TRK_A:   d.rdata = q.trk_a;
        ADDR_TRK_B:   d.rdata = q.trk_b;
        ADDR_TRK_C:   d.rdata = q.trk_c;
        default:      d.rdata = RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      q           <= '0;
      q.clk_pwr   <= RST_CLK_PWR; // RULE21
      q.fb_cnt    <= RST_FB_CNT;
      q.st        <= ST_IDLE;
      q.ref_ratio <= 5'h01;
      q.vco_ratio <= 5'h04;
      q.mult      <= 9'h00c;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata               = q.rdata;
  assign loop_enable             = q.ctrl[CTRL_EN_BIT];
  assign cp_cal_run              = (q.st == ST_CPCAL);
  assign cp_cal_valid            = q.cal_done;
  assign band_search_run         = (q.st == ST_BAND);
  assign vco_band                = q.band;
  assign feedback_divide_count   = q.fb_cnt;
  assign sample_clock_multiplier = q.mult;
  assign reference_divide_ratio  = q.ref_ratio;
  assign vco_output_divide_ratio = q.vco_ratio;
  assign charge_pump_code        = q.cp;
  assign loop_filter_a           = q.lf_a;
  assign loop_filter_b           = q.lf_b;
  assign loop_filter_c           = q.lf_c;
  assign vco_tracking_a          = q.trk_a;
  assign vco_tracking_b          = q.trk_b;
  assign vco_tracking_c          = q.trk_c;
  assign clock_power_up          = ~q.clk_pwr[7:3];

endmodule
`default_nettype wire

/* dpc_pkg.sv */
package dpc_pkg;

  // register map
  localparam logic [8:0] ADDR_IRQ_EN   = 9'h01f;
  localparam logic [8:0] ADDR_IRQ_ST   = 9'h023;
  localparam logic [8:0] ADDR_CLK_PWR  = 9'h080;
  localparam logic [8:0] ADDR_CTRL     = 9'h083;
  localparam logic [8:0] ADDR_STATUS   = 9'h084;
  localparam logic [8:0] ADDR_FB_CNT   = 9'h085;
  localparam logic [8:0] ADDR_LF_A     = 9'h087;
  localparam logic [8:0] ADDR_LF_B     = 9'h088;
  localparam logic [8:0] ADDR_LF_C     = 9'h089;
  localparam logic [8:0] ADDR_CP       = 9'h08a;
  localparam logic [8:0] ADDR_VDIV     = 9'h08b;
  localparam logic [8:0] ADDR_RDIV     = 9'h08c;
  localparam logic [8:0] ADDR_TRK_A    = 9'h1b5;
  localparam logic [8:0] ADDR_TRK_B    = 9'h1bb;
  localparam logic [8:0] ADDR_TRK_C    = 9'h1c5;

  // field positions
  localparam int CTRL_EN_BIT    = 4;
  localparam int CTRL_RECAL_BIT = 7;
  localparam int ST_UPPER_BIT   = 7;
  localparam int ST_LOWER_BIT   = 6;
  localparam int ST_CAL_BIT     = 5;
  localparam int ST_LOCK_BIT    = 1;
  localparam int IRQ_LOCK_BIT   = 4;
  localparam int IRQ_LOST_BIT   = 5;
  localparam int CP_W           = 6;
  localparam int BAND_W         = 9;

  // reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_CLK_PWR = 8'hf8;
  localparam logic [7:0] RST_FB_CNT  = 8'h06;

  // timing counts, in reference clock cycles, and band search start values
  localparam logic [6:0] CP_CAL_LAST = 7'h3f;
  localparam logic [6:0] SETTLE_LAST = 7'h0f;
  localparam logic [8:0] BAND_MID    = 9'h100;
  localparam logic [3:0] BAND_TOP    = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CPCAL = 2'b01,
    ST_BAND  = 2'b11,
    ST_TRACK = 2'b10
  } dpc_state_t;

  typedef struct packed {
    logic [7:0]        irq_en;
    logic [7:0]        irq_st;
    logic [7:0]        clk_pwr;
    logic [7:0]        ctrl;
    logic [7:0]        fb_cnt;
    logic [7:0]        lf_a;
    logic [7:0]        lf_b;
    logic [7:0]        lf_c;
    logic [CP_W-1:0]   cp;
    logic [1:0]        vdiv;
    logic [2:0]        rdiv;
    logic [7:0]        trk_a;
    logic [7:0]        trk_b;
    logic [7:0]        trk_c;
    logic [7:0]        rdata;
    logic [3:0]        s1;
    logic [3:0]        s2;
    logic              lock_prev;
    dpc_state_t        st;
    logic              cal_done;
    logic [6:0]        cnt;
    logic [3:0]        bit_idx;
    logic [BAND_W-1:0] band;
    logic [4:0]        ref_ratio;
    logic [4:0]        vco_ratio;
    logic [8:0]        mult;
  } dpc_regs_t;

  function automatic logic [4:0] dpc_ref_ratio(input logic [2:0] sel);
    unique case (sel)
      3'h0:    dpc_ref_ratio = 5'h01;
      3'h1:    dpc_ref_ratio = 5'h02;
      3'h2:    dpc_ref_ratio = 5'h04;
      3'h3:    dpc_ref_ratio = 5'h08;
      3'h4:    dpc_ref_ratio = 5'h10;
      default: dpc_ref_ratio = 5'h01;
    endcase
  endfunction

  function automatic logic [4:0] dpc_vco_ratio(input logic [1:0] sel);
    unique case (sel)
      2'h1:    dpc_vco_ratio = 5'h04;
      2'h2:    dpc_vco_ratio = 5'h08;
      2'h3:    dpc_vco_ratio = 5'h10;
      default: dpc_vco_ratio = 5'h04;
    endcase
  endfunction

endpackage

/* dpc_loop_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dpc_loop_ctrl_chk
  import dpc_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       nrst,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [8:0]                 reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       loop_enable,
  input wire logic                       cp_cal_run,
  input wire logic                       cp_cal_valid,
  input wire logic                       band_search_run,
  input wire logic [dpc_pkg::BAND_W-1:0] vco_band,
  input wire logic [7:0]                 feedback_divide_count,
  input wire logic [8:0]                 sample_clock_multiplier,
  input wire logic [dpc_pkg::CP_W-1:0]   charge_pump_code
);
  import dpc_pkg::*;
  logic [7:0] wd_q;
  logic [7:0] cal_len;
  always_ff @(posedge clock) begin
    wd_q    <= reg_wdata;
    cal_len <= cp_cal_run ? cal_len + 8'h01 : 8'h00;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_cal_length: assert property ($fell(cp_cal_run) |-> cal_len == 8'h40)
    else $error("calibration length wrong");
  chk_cal_handoff: assert property ($fell(cp_cal_run) |->
    cp_cal_valid && band_search_run)
    else $error("calibration end not flagged");
  chk_cal_once: assert property (cp_cal_valid |-> !cp_cal_run)
    else $error("calibration rerun");
  chk_mult_twice: assert property (reg_wr && reg_addr == ADDR_FB_CNT |=>
    feedback_divide_count == wd_q ##1
    sample_clock_multiplier == {$past(feedback_divide_count), 1'b0})
    else $error("multiplier mismatch");
  chk_enable_bit: assert property (reg_wr && reg_addr == ADDR_CTRL |=>
    loop_enable == wd_q[CTRL_EN_BIT])
    else $error("enable bit mismatch");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  chk_cp_code: assert property (reg_wr && reg_addr == ADDR_CP |=>
    charge_pump_code == wd_q[CP_W-1:0])
    else $error("charge pump code mismatch");
  chk_band_start: assert property ($rose(band_search_run) |->
    vco_band == BAND_MID)
    else $error("band search start wrong");
endmodule
bind dpc_loop_ctrl dpc_loop_ctrl_chk chk_i (.*);
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dpc_pkg::*;
  logic       clock = 1'b0;
  logic       nrst, reg_wr, reg_rd, lock_raw, up_raw, low_raw, fast_raw;
  logic [8:0] reg_addr, vco_band, mult;
  logic [7:0] reg_wdata, reg_rdata, fb;
  logic       loop_enable, cp_cal_run, cp_cal_valid, band_search_run;
  logic [4:0] rref, rvco, pwr;
  logic [5:0] cp;
  int         err_total, comparisons, n;
  dpc_loop_ctrl uut (.clock(clock), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .lock_detect_raw(lock_raw),
    .band_upper_raw(up_raw), .band_lower_raw(low_raw),
    .vco_fast_raw(fast_raw), .loop_enable(loop_enable),
    .cp_cal_run(cp_cal_run), .cp_cal_valid(cp_cal_valid),
    .band_search_run(band_search_run), .vco_band(vco_band),
    .feedback_divide_count(fb), .sample_clock_multiplier(mult),
    .reference_divide_ratio(rref), .vco_output_divide_ratio(rvco),
    .charge_pump_code(cp), .loop_filter_a(), .loop_filter_b(),
    .loop_filter_c(), .vco_tracking_a(), .vco_tracking_b(),
    .vco_tracking_c(), .clock_power_up(pwr));
  initial forever #50 clock = ~clock;
  task automatic chk(input string nm, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wcyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    chk($sformatf("reg %h", a), reg_rdata, e);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
  initial begin
    {nrst, reg_wr, reg_rd, lock_raw, up_raw, low_raw, fast_raw} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rd_chk(ADDR_CLK_PWR, RST_CLK_PWR);
    rd_chk(ADDR_FB_CNT, RST_FB_CNT);
    chk("mult", mult, 16'h00c);
    chk("pwr", pwr, 16'h0);
    wr(ADDR_CLK_PWR, 8'h00);
    wr(ADDR_FB_CNT, 8'h7f);
    rd_chk(ADDR_FB_CNT, 8'h7f);
    chk("mult", mult, 16'h0fe);
    chk("pwr", pwr, 16'h1f);
    wr(ADDR_CP, 8'hff);
    rd_chk(ADDR_CP, 8'h3f);
    wr(ADDR_LF_B, 8'hc9);
    rd_chk(ADDR_LF_B, 8'hc9);
    rd_chk(9'h100, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_RDIV, 8'(i));
      wcyc(3);
      chk("ref ratio", rref, 16'h1 << i);
    end
    for (int i = 1; i < 4; i++) begin
      wr(ADDR_VDIV, 8'(i));
      wcyc(3);
      chk("vco ratio", rvco, 16'h2 << i);
    end
    wr(ADDR_LF_A, 8'h62);
    wr(ADDR_VDIV, 8'h02);
    wr(ADDR_FB_CNT, 8'h10);
    wr(ADDR_RDIV, 8'h03);
    wr(ADDR_TRK_A, 8'h09);
    wr(ADDR_TRK_B, 8'h13);
    wr(ADDR_TRK_C, 8'h06);
    rd_chk(ADDR_TRK_A, 8'h09);
    rd_chk(ADDR_TRK_B, 8'h13);
    rd_chk(ADDR_TRK_C, 8'h06);
    rd_chk(ADDR_VDIV, 8'h02);
    rd_chk(ADDR_RDIV, 8'h03);
    wr(ADDR_IRQ_EN, 8'h30);
    fast_raw <= 1'b1;
    wr(ADDR_CTRL, 8'h10);
    n = 0;
    while (cp_cal_run !== 1'b1 && n < 9) begin
      wcyc(1);
      n++;
    end
    n = 0;
    while (cp_cal_run === 1'b1 && n < 99) begin
      n++;
      wcyc(1);
    end
    chk("cal length", 16'(n), 16'd64);
    chk("cal valid", cp_cal_valid, 16'h1);
    chk("band start", vco_band, BAND_MID);
    rd_chk(ADDR_STATUS, 8'h20);
    wcyc(150);
    chk("search end", band_search_run, 16'h0);
    chk("band low", vco_band, 16'h000);
    @(posedge clock) lock_raw <= 1'b1;
    wcyc(4);
    rd_chk(ADDR_STATUS, 8'h22);
    rd_chk(ADDR_IRQ_ST, 8'h10);
    wr(ADDR_STATUS, 8'h00);
    rd_chk(ADDR_STATUS, 8'h22);
    wr(ADDR_IRQ_ST, 8'h10);
    rd_chk(ADDR_IRQ_ST, 8'h00);
    @(posedge clock);
    lock_raw <= 1'b0;
    up_raw   <= 1'b1;
    low_raw  <= 1'b1;
    fast_raw <= 1'b0;
    wcyc(4);
    rd_chk(ADDR_STATUS, 8'he0);
    rd_chk(ADDR_IRQ_ST, 8'h20);
    wr(ADDR_CTRL, 8'h90);
    wcyc(3);
    chk("recal", band_search_run, 16'h1);
    wcyc(150);
    chk("band high", vco_band, 16'h1ff);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    wcyc(3);
    chk("no recal cp", cp_cal_run, 16'h0);
    chk("restart", band_search_run, 16'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
